// [core/sipo_core.sv]
// sipo_core: serial-in shift stages, holding latch, three-state parallel outputs
// assumes: all pins asynchronous to clk_in, sampled by two flops; pin clocks well below clk_in/2
// Overview of operation
// (R1) each shift clock rise with reset high loads the serial bit into stage one and moves every stage one place on.
// (R2) with no shift clock rise and reset high the stages hold.
// (R3) reset low clears stages and chain output but leaves the held bits alone.
// (R4) each latch clock rise copies all eight stages into the held bits.
// (R5) with no latch clock rise the held bits hold whatever reset and shift clock do.
// (R6) output enable low drives the held bits onto the parallel outputs.
// (R7) output enable high floats all parallel outputs without touching any contents.
// (R8) the chain output is always driven.
// (R9) the chain output shows the eighth stage.
// (R10) parallel outputs are uninverted, stage one on output zero up to stage eight on output seven.
// (R11) the host shifts eight bits, last output first, and then raises the latch clock.
// (R12) the host keeps reset high while a frame is being shifted.
module sipo_core (
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_n_in,
   // device pins
   input wire logic serial_bit_in,
   input wire logic shift_clk_in,
   input wire logic latch_clk_in,
   input wire logic clear_n_in,
   input wire logic out_en_n_in,
   // parallel outputs, three-state as value plus enable
   output logic [7:0] latched_outputs_out,
   output logic [7:0] latched_outputs_oe_out,
   output logic chain_out,
   // copy of each latched word the fifo has room for, drained by the user
   output logic word_valid_out,
   output logic [7:0] word_data_out,
   input wire logic word_ready_in
);
   // ************************************************
   // state
   // ************************************************
   typedef struct packed {
      logic [4:0] s1;
      logic [4:0] s2;
      logic [4:0] dly;
      logic [7:0] stage_bits;
      logic [7:0] held_bits;
      logic [7:0] q;
      logic [7:0] oe;
      logic chain;
      logic push;
   } sipo_st_s;
   sipo_st_s st_r, st_nxt;
   logic sh_rise, la_rise, clr_n, oe_n, sbit;
   sipo_fifo_if #(.W(8)) fifo_wr ();

   // ************************************************
   // synchronisers and edge finders
   // ************************************************
   // sync order: 4 serial,3 shift,2 latch,1 clear_n,0 oe_n
   assign sbit = st_r.s2[4];
   assign clr_n = st_r.s2[1];
   assign oe_n = st_r.s2[0];
   assign sh_rise = st_r.s2[3] && !st_r.dly[3];
   assign la_rise = st_r.s2[2] && !st_r.dly[2];

   function automatic logic [7:0] shift_in(input logic [7:0] v, input logic b);
      shift_in = {v[6:0], b};
   endfunction

   always_comb begin
      st_nxt = st_r;
      st_nxt.push = 1'b0;
      st_nxt.s1 = {serial_bit_in, shift_clk_in, latch_clk_in, clear_n_in, out_en_n_in};
      st_nxt.s2 = st_r.s1;
      st_nxt.dly = st_r.s2;
      // clear wins over a coincident shift edge; held bits sample old stages
      if (!clr_n) begin
         st_nxt.stage_bits = sipo_pkg::STAGE_RESET; // R3
      end else if (sh_rise) begin
         st_nxt.stage_bits = shift_in(st_r.stage_bits, sbit); // R1
      end
      // otherwise stage_bits keep their value R2
      if (la_rise) begin
         st_nxt.held_bits = st_r.stage_bits; // R4
         // a full fifo drops the copy; the pins never wait on software
         st_nxt.push = 1'b1;
      end
      // no else: held bits untouched by clear or shift R5
      st_nxt.q = st_nxt.held_bits; // R10
      st_nxt.oe = (oe_n == sipo_pkg::OE_OFF) ? 8'h00 : 8'hff; // R6 R7
      st_nxt.chain = st_nxt.stage_bits[sipo_pkg::STAGES-1]; // R9
      if (!rst_n_in) begin
         st_nxt = '0;
         st_nxt.s1 = 5'h03;
         st_nxt.s2 = 5'h03;
         st_nxt.dly = 5'h03;
         st_nxt.held_bits = sipo_pkg::HELD_RESET;
      end
   end

   always_ff @(posedge clk_in) begin
      st_r <= st_nxt;
   end

   // ************************************************
   // outputs
   // ************************************************
   assign latched_outputs_out = st_r.q;
   assign latched_outputs_oe_out = st_r.oe;
   assign chain_out = st_r.chain; // R8
   assign fifo_wr.valid = st_r.push;
   assign fifo_wr.data = st_r.held_bits;

   sipo_fifo #(
      .W(8),
      .DEPTH(sipo_pkg::FIFO_DEPTH),
      .AW(sipo_pkg::FIFO_AW)
   ) u_fifo (
      .clk_in(clk_in),
      .rst_n_in(rst_n_in),
      .wr(fifo_wr),
      .rd_valid_out(word_valid_out),
      .rd_data_out(word_data_out),
      .rd_ready_in(word_ready_in)
   );
endmodule

// [core/sipo_pkg.sv]
// sipo_pkg: widths, reset values and a fifo depth for the serial-in latched-out register
// assumes: included first in compile order, nothing imported by users
package sipo_pkg;
   // ************************************************
   // widths and reset values
   // ************************************************
   localparam int STAGES = 8;
   localparam logic [7:0] STAGE_RESET = 8'h00;
   localparam logic [7:0] HELD_RESET = 8'h00;
   localparam int FIFO_DEPTH = 8;
   localparam int FIFO_AW = 3;
   // oe active low: 1 means outputs float
   localparam logic OE_OFF = 1'b1;
endpackage

// [core/sipo_fifo_if.sv]
// sipo_fifo_if: valid/ready word channel between the core and its fifo
// assumes: one clock shared by both ends
interface sipo_fifo_if #(parameter int W = 8) ();
   logic valid;
   logic ready;
   logic [W-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface

// [core/sipo_fifo.sv]
// sipo_fifo: small synchronous fifo with registered read data
// assumes: single clock, synchronous active-low reset
module sipo_fifo #(
   parameter int W = 8,
   parameter int DEPTH = 8,
   parameter int AW = 3
) (
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_n_in,
   // filling side
   sipo_fifo_if.snk wr,
   // draining side
   output logic rd_valid_out,
   output logic [W-1:0] rd_data_out,
   input wire logic rd_ready_in
);
   // ************************************************
   // storage and pointers
   // ************************************************
   typedef struct packed {
      logic [AW:0] wp;
      logic [AW:0] rp;
      logic [W-1:0] dout;
      logic dvalid;
   } sipo_fst_s;
   sipo_fst_s st_r, st_nxt;
   logic [W-1:0] mem_r [DEPTH];
   logic full, empty, push, pop;

   assign full = (st_r.wp[AW-1:0] == st_r.rp[AW-1:0]) && (st_r.wp[AW] != st_r.rp[AW]);
   assign empty = (st_r.wp == st_r.rp);
   assign wr.ready = !full;
   assign push = wr.valid && !full;
   // output register refills when empty or being taken
   assign pop = !empty && (!st_r.dvalid || rd_ready_in);
   assign rd_valid_out = st_r.dvalid;
   assign rd_data_out = st_r.dout;

   always_comb begin
      st_nxt = st_r;
      if (push) begin
         st_nxt.wp = st_r.wp + 1'b1;
      end
      if (pop) begin
         st_nxt.rp = st_r.rp + 1'b1;
         st_nxt.dout = mem_r[st_r.rp[AW-1:0]];
         st_nxt.dvalid = 1'b1;
      end else if (rd_ready_in) begin
         st_nxt.dvalid = 1'b0;
      end
      if (!rst_n_in) begin
         st_nxt = '0;
      end
   end

   always_ff @(posedge clk_in) begin
      st_r <= st_nxt;
      if (push) begin
         mem_r[st_r.wp[AW-1:0]] <= wr.data;
      end
   end
endmodule

// [verification/sipo_core_sva.sv]
// sipo_core_sva: pin-level checks against a shadow of the stages
// assumes: pin pulses and spacing as the core's contract allows
module sipo_core_sva (
   // clock, reset and pins
   input wire logic clk_in, rst_n_in, serial_bit_in, shift_clk_in, latch_clk_in, clear_n_in, out_en_n_in,
   // outputs and fifo handshake
   input wire logic [7:0] latched_outputs_out, latched_outputs_oe_out, word_data_out,
   input wire logic chain_out, word_valid_out, word_ready_in
);
   timeunit 1ns;
   timeprecision 100ps;
   // shadow skips the sync delay, so compare only after quiet spells
   logic [7:0] stg_r, held_r;
   default clocking @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);
   always_ff @(posedge clk_in) begin
      if (!rst_n_in || !clear_n_in) stg_r <= 8'h00;
      else if ($rose(shift_clk_in)) stg_r <= {stg_r[6:0], serial_bit_in};
   end
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) held_r <= 8'h00;
      else if ($rose(latch_clk_in)) held_r <= stg_r;
   end
   a_oe_on: assert property ((!out_en_n_in)[*4] |-> latched_outputs_oe_out == 8'hff)
      else $error("outputs not driven");
   a_oe_off: assert property ((out_en_n_in)[*4] |-> latched_outputs_oe_out == 8'h00)
      else $error("outputs not floating");
   a_oe_whole: assert property (latched_outputs_oe_out == 8'h00 || latched_outputs_oe_out == 8'hff)
      else $error("enable split");
   a_chain_stage: assert property ((clear_n_in && !$rose(shift_clk_in))[*5] |-> chain_out == stg_r[7])
      else $error("chain not stage eight");
   a_chain_clear: assert property ((!clear_n_in)[*5] |-> chain_out == 1'b0)
      else $error("chain not cleared");
   a_held_match: assert property ((!$rose(latch_clk_in))[*5] |-> latched_outputs_out == held_r)
      else $error("held bits wrong");
   a_word_push: assert property ($rose(latch_clk_in) |-> ##[4:6] word_valid_out)
      else $error("no word pushed");
   a_word_hold: assert property (word_valid_out && !word_ready_in |=> word_valid_out && $stable(word_data_out))
      else $error("word dropped");
   c_shift: cover property ($rose(shift_clk_in));
   c_latch: cover property ($rose(latch_clk_in));
   c_take: cover property (word_valid_out && word_ready_in);
endmodule
bind sipo_core sipo_core_sva chk_u (.clk_in, .rst_n_in, .serial_bit_in, .shift_clk_in, .latch_clk_in,
   .clear_n_in, .out_en_n_in, .latched_outputs_out, .latched_outputs_oe_out, .word_data_out,
   .chain_out, .word_valid_out, .word_ready_in);

// [verification/sipo_host_model.sv]
// sipo_host_model: serial master, eight bits msb first then a latch pulse
// assumes: go_in pulsed only while busy_out is low
module sipo_host_model (
   input wire logic go_in,
   input wire logic [7:0] byte_in,
   output logic sdata_out, sclk_out, lclk_out, busy_out
);
   timeunit 1ns;
   timeprecision 100ps;
   initial {sdata_out, sclk_out, lclk_out, busy_out} = 4'h0;
   // 80 ns link clock, still between frames
   always @(posedge go_in) begin
      busy_out = 1'b1;
      for (int i = 7; i >= 0; i--) begin
         sdata_out = byte_in[i];
         #40 sclk_out = 1'b1;
         #40 sclk_out = 1'b0;
      end
      sdata_out = ~sdata_out; // released line must not look held
      #40 lclk_out = 1'b1;
      #40 lclk_out = 1'b0;
      busy_out = 1'b0;
   end
endmodule

// [verification/sipo_core_test.sv]
// sipo_core_test: frames, fifo fill and drain, enable and clear
// assumes: checker bound to the core
module sipo_core_test;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk_in = 0, rst_n_in = 0, clear_n = 1, oe_n = 1, ready = 0, go = 0, busy, sd, sc, lc, chain, wv;
   logic [7:0] b = 8'h00, q, oe, wd;
   int failures = 0, checks = 0;
   initial forever #5 clk_in = ~clk_in;
   sipo_host_model host_u (.go_in(go), .byte_in(b), .sdata_out(sd), .sclk_out(sc), .lclk_out(lc), .busy_out(busy));
   sipo_core dut_u (.clk_in, .rst_n_in, .serial_bit_in(sd), .shift_clk_in(sc), .latch_clk_in(lc),
      .clear_n_in(clear_n), .out_en_n_in(oe_n), .latched_outputs_out(q), .latched_outputs_oe_out(oe),
      .chain_out(chain), .word_valid_out(wv), .word_data_out(wd), .word_ready_in(ready));
   function automatic logic [7:0] exp_w(int i);
      return 8'h12 + 8'h1d * 8'(i);
   endfunction
   task automatic chk(string name, logic [7:0] seen, logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic tally_and_finish();
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic tick(int n);
      repeat (n) @(posedge clk_in);
      #1;
   endtask
   task automatic send(logic [7:0] v);
      b = v;
      go = 1'b1;
      tick(1);
      go = 1'b0;
      for (int n = 0; n < 200 && busy; n++) tick(1);
      if (busy !== 1'b0) begin
         failures++;
         tally_and_finish();
      end
      tick(6);
   endtask
   // ten frames with ready low: eight in memory plus the output register, so the tenth is dropped
   task automatic t_frames();
      for (int i = 0; i < 10; i++) begin
         send(exp_w(i));
         chk("parallel", q, exp_w(i));
         chk("chain", {7'h00, chain}, exp_w(i) >> 7);
      end
   endtask
   task automatic t_drain();
      for (int i = 0; i < 9; i++) begin
         chk("word", wd, exp_w(i));
         chk("valid", {7'h00, wv}, 8'h01);
         ready = 1'b1;
         tick(1);
         ready = 1'b0;
         tick(1);
      end
      chk("empty", {7'h00, wv}, 8'h00);
   endtask
   task automatic t_oe_clear();
      tick(5);
      chk("float", oe, 8'h00);
      oe_n = 1'b0;
      tick(5);
      chk("drive", oe, 8'hff);
      chk("kept", q, exp_w(9));
      clear_n = 1'b0;
      tick(6);
      chk("cleared", {7'h00, chain}, 8'h00);
      chk("held", q, exp_w(9));
      clear_n = 1'b1;
      tick(4);
   endtask
   initial begin
      tick(2);
      rst_n_in = 1'b1;
      tick(4);
      t_frames();
      t_drain();
      t_oe_clear();
      tally_and_finish();
   end
endmodule
